// ==== flash_host_end.sv ====
// Host end: power-up waits and serial command framing on the link.
`timescale 1ns/1ps
module flash_host_end #(
  parameter int unsigned SELECT_WAIT_CYCLES =
    flash_link_pkg::SUPPLY_TO_SELECT_CYCLES, // Wait before any select.
  parameter int unsigned WRITE_WAIT_CYCLES =
    flash_link_pkg::POWER_UP_WRITE_CYCLES // Wait before program, erase.
) (
  input wire logic clock, // System clock, 200 MHz.
  input wire logic rst, // Reset, active high.
  flash_link_if.host link, // Serial link pins.
  input wire logic cmdStart, // One-cycle request to send a command.
  input wire logic [7:0] cmdOpcode, // Opcode to send.
  input wire logic [9:0] cmdPage, // Page field to send.
  input wire logic [8:0] cmdOffset, // Byte offset to send.
  input wire logic cmdMode3, // 1 sends in mode 3, 0 in mode 0.
  output logic busy, // High while a command is in flight.
  output logic cmdDone, // One-cycle pulse, command sent.
  output logic cmdRefused, // One-cycle pulse, request refused.
  output logic selectReady, // Select wait has elapsed.
  output logic writeReady // Program and erase wait has elapsed.
);

  typedef enum logic [2:0] {
    IDLE = 3'b000,
    SELECT = 3'b001,
    SHIFT = 3'b011,
    HOLD = 3'b010,
    DESELECT = 3'b110
  } host_state_e;

  host_state_e stateQ;
  host_state_e stateD;
  logic [22:0] puCntQ;
  logic [22:0] puCntD;
  logic [3:0] tCntQ;
  logic [3:0] tCntD;
  logic [6:0] sentQ;
  logic [6:0] sentD;
  logic [6:0] bitsQ;
  logic [6:0] bitsD;
  logic [63:0] frameQ;
  logic [63:0] frameD;
  logic sckQ;
  logic sckD;
  logic csNQ;
  logic csND;
  logic modeQ;
  logic modeD;
  logic doneQ;
  logic doneD;
  logic refusedQ;
  logic refusedD;
  logic selOk;
  logic wrOk;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    stateD = stateQ;
    tCntD = tCntQ + 4'h1;
    sentD = sentQ;
    bitsD = bitsQ;
    frameD = frameQ;
    sckD = sckQ;
    csND = csNQ;
    modeD = modeQ;
    doneD = 1'b0;
    refusedD = 1'b0;
    selOk = (puCntQ >= 23'(SELECT_WAIT_CYCLES));
    wrOk = (puCntQ >= 23'(WRITE_WAIT_CYCLES));
    puCntD = wrOk ? puCntQ : puCntQ + 23'h1;
    case (stateQ)
      IDLE:
      begin
        tCntD = 4'h0;
        if (cmdStart)
        begin
          if (!selOk || (flash_link_pkg::isWriteOp(cmdOpcode) && !wrOk))
          begin
            refusedD = 1'b1;
          end
          else
          begin
            frameD = {cmdOpcode, 5'h0, cmdPage, cmdOffset, 32'h0};
            bitsD = flash_link_pkg::frameBits(cmdOpcode);
            sentD = 7'h0;
            modeD = cmdMode3;
            sckD = cmdMode3;
            stateD = SELECT;
          end
        end
      end
      SELECT:
      begin
        if (tCntQ == flash_link_pkg::SCK_HALF_LAST)
        begin
          csND = 1'b0;
          tCntD = 4'h0;
          stateD = SHIFT;
        end
      end
      SHIFT:
      begin
        if (tCntQ == flash_link_pkg::SCK_HALF_LAST)
        begin
          tCntD = 4'h0;
          if (!sckQ)
          begin
            sckD = 1'b1;
            sentD = sentQ + 7'h1;
            if (sentD == bitsQ)
            begin
              stateD = HOLD;
            end
          end
          else
          begin
            sckD = 1'b0;
            if (sentQ != 7'h0)
            begin
              frameD = {frameQ[62:0], 1'b0};
            end
          end
        end
      end
      HOLD:
      begin
        if (tCntQ == flash_link_pkg::SCK_HALF_LAST)
        begin
          sckD = modeQ;
          csND = 1'b1;
          tCntD = 4'h0;
          stateD = DESELECT;
        end
      end
      DESELECT:
      begin
        if (tCntQ == flash_link_pkg::CS_HIGH_LAST)
        begin
          frameD = 64'h0;
          doneD = 1'b1;
          stateD = IDLE;
        end
      end
      default:
      begin
        stateD = IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      stateQ <= IDLE;
      puCntQ <= 23'h0;
      tCntQ <= 4'h0;
      sentQ <= 7'h0;
      bitsQ <= 7'h0;
      frameQ <= 64'h0;
      sckQ <= 1'b1;
      csNQ <= 1'b1;
      modeQ <= 1'b1;
      doneQ <= 1'b0;
      refusedQ <= 1'b0;
    end
    else
    begin
      stateQ <= stateD;
      puCntQ <= puCntD;
      tCntQ <= tCntD;
      sentQ <= sentD;
      bitsQ <= bitsD;
      frameQ <= frameD;
      sckQ <= sckD;
      csNQ <= csND;
      modeQ <= modeD;
      doneQ <= doneD;
      refusedQ <= refusedD;
    end
  end

  assign link.csN = csNQ;
  assign link.sck = sckQ;
  assign link.si = frameQ[63];
  assign busy = (stateQ != IDLE);
  assign cmdDone = doneQ;
  assign cmdRefused = refusedQ;
  assign selectReady = selOk;
  assign writeReady = wrOk;

endmodule : flash_host_end

// ==== flash_link_pkg.sv ====
// Shared constants, command framing layout and helper functions.
package flash_link_pkg;

  // ----------------------------------------------------------------
  // Command frame layout
  // ----------------------------------------------------------------
  localparam int OPCODE_BITS = 8;
  localparam int ADDR_BITS = 24;
  localparam int ADDR_RESERVED_MSB = 23;
  localparam int ADDR_RESERVED_LSB = 19;
  localparam int PAGE_ADDR_MSB = 18;
  localparam int PAGE_ADDR_LSB = 9;
  localparam int BYTE_OFFSET_MSB = 8;
  localparam int BYTE_OFFSET_LSB = 0;
  localparam logic [6:0] HEADER_BITS = 7'h20;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_PAGE_READ = 8'hd2;
  localparam logic [7:0] OP_CONT_READ = 8'he8;
  localparam logic [7:0] OP_BUF_TO_PAGE_ERASE = 8'h83;
  localparam logic [7:0] OP_BUF_TO_PAGE = 8'h88;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_PROG_THRU_BUF = 8'h82;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
  localparam logic [7:0] OP_AUTO_REWRITE = 8'h58;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ = 200;
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int SUPPLY_TO_SELECT_DELAY_US = 50;
  localparam int POWER_UP_WRITE_DELAY_MS = 20;
  localparam int CS_HIGH_NS = 50;
  localparam int SUPPLY_TO_SELECT_CYCLES =
    SUPPLY_TO_SELECT_DELAY_US * CLOCK_MHZ;
  localparam int POWER_UP_WRITE_CYCLES =
    POWER_UP_WRITE_DELAY_MS * 1000 * CLOCK_MHZ;
  localparam int CS_HIGH_CYCLES =
    (CS_HIGH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [3:0] CS_HIGH_LAST = 4'(CS_HIGH_CYCLES - 1);
  localparam logic [3:0] SCK_HALF_LAST = 4'h1;

  // Number of dummy bytes that trail the address for an opcode.
  function automatic logic [2:0] dummyBytes(input logic [7:0] op);
    case (op)
      OP_FAST_READ: dummyBytes = 3'h1;
      OP_PAGE_READ, OP_CONT_READ: dummyBytes = 3'h4;
      default: dummyBytes = 3'h0;
    endcase
  endfunction : dummyBytes

  // Total serial bits of an addressed command frame.
  function automatic logic [6:0] frameBits(input logic [7:0] op);
    frameBits = HEADER_BITS + {1'b0, dummyBytes(op), 3'h0};
  endfunction : frameBits

  // Opcodes that program or erase the array.
  function automatic logic isWriteOp(input logic [7:0] op);
    case (op)
      OP_BUF_TO_PAGE_ERASE, OP_BUF_TO_PAGE, OP_PAGE_ERASE,
      OP_PROG_THRU_BUF, OP_BLOCK_ERASE, OP_AUTO_REWRITE: isWriteOp = 1'b1;
      default: isWriteOp = 1'b0;
    endcase
  endfunction : isWriteOp

endpackage : flash_link_pkg

// ==== flash_link_if.sv ====
// Serial link wires between the flash device end and the host end.
`timescale 1ns/1ps
interface flash_link_if;
  logic csN; // Device select, active low.
  logic sck; // Serial clock, made by the host.
  logic si; // Serial data into the device.
  logic so; // Serial data out of the device.
  logic soOeN; // Output enable of so, low while driven.

  modport device (
    input csN,
    input sck,
    input si,
    output so,
    output soOeN
  );

  modport host (
    output csN,
    output sck,
    output si,
    input so,
    input soOeN
  );
endinterface : flash_link_if

// ==== flash_device_end.sv ====
// Device end: command framing on the serial clock, power-on state.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Overview of operation
// - Default to mode 3 after reset.
// - Data output stays high impedance after reset.
// - Commands start only after select falls.
// - Select fall samples clock idle, picks mode.
// - Commands ignored while power-on reset asserted; a command whose select fell in its last two cycles is still taken.
// - Host waits 50 us before selecting.
// - Host waits 20 ms before program, erase.
// - Settle into standby after power-up.
// - Opcode, three address bytes, opcode dummy bytes.
// - Five reserved bits, then 10-bit page.
// - Last nine bits are byte offset.
// ----------------------------------------------------------------
module flash_device_end (
  input wire logic clock, // System clock, 200 MHz.
  input wire logic rst, // Power-on reset, active high.
  flash_link_if.device link, // Serial link pins.
  output logic cmdValid, // One-cycle pulse, a framed command.
  output logic [7:0] cmdOpcode, // Opcode of last command.
  output logic [9:0] cmdPage, // Page field of last command.
  output logic [8:0] cmdOffset, // Byte offset of last command.
  output logic cmdMode3, // Serial mode of last command, 1 is mode 3.
  output logic standby // High while idle and out of reset.
);

  // ----------------------------------------------------------------
  // Data output
  // ----------------------------------------------------------------
  // output held released
  // No command in this block drives data back, so the pin is released.
  assign link.so = 1'b0;
  assign link.soOeN = 1'b1;

  // ----------------------------------------------------------------
  // Link domain: frame shifter
  // ----------------------------------------------------------------
  logic [6:0] bitCntQ;
  logic [6:0] bitCntD;
  logic [31:0] shiftQ;
  logic [31:0] shiftD;
  logic [31:0] capQ;
  logic [31:0] capD;
  logic doneQ;
  logic doneD;
  logic [7:0] curOp;
  logic sckIdleQ;

  always_comb
  begin
    shiftD = shiftQ;
    bitCntD = bitCntQ;
    capD = capQ;
    doneD = doneQ;
    curOp = capQ[31:24];
    if (!doneQ)
    begin
      shiftD = {shiftQ[30:0], link.si};
      bitCntD = bitCntQ + 7'h1;
      if (bitCntD == flash_link_pkg::HEADER_BITS)
      begin
        capD = shiftD;
        curOp = shiftD[31:24];
      end
      if (bitCntD >= flash_link_pkg::HEADER_BITS &&
          bitCntD == flash_link_pkg::frameBits(curOp))
      begin
        doneD = 1'b1;
      end
    end
  end

  // frame starts at select
  // Raising select clears the frame, so an aborted command never
  // completes and the next one always starts at bit zero.
  always_ff @(posedge link.sck or posedge link.csN)
  begin
    if (link.csN)
    begin
      bitCntQ <= 7'h0;
      shiftQ <= 32'h0;
      doneQ <= 1'b0;
    end
    else
    begin
      bitCntQ <= bitCntD;
      shiftQ <= shiftD;
      doneQ <= doneD;
    end
  end

  // The captured header is only read after doneQ has crossed, so it
  // needs no reset and stays stable while the other side takes it.
  always_ff @(posedge link.sck)
  begin
    capQ <= capD;
  end

  always_ff @(negedge link.csN)
  begin
    sckIdleQ <= link.sck;
  end

  // ----------------------------------------------------------------
  // System domain: crossing and command hand-off
  // ----------------------------------------------------------------
  logic [2:0] csPipeQ;
  logic [2:0] csPipeD;
  logic [2:0] donePipeQ;
  logic [2:0] donePipeD;
  logic frameOkQ;
  logic frameOkD;
  logic cmdValidQ;
  logic cmdValidD;
  logic [7:0] opQ;
  logic [7:0] opD;
  logic [9:0] pageQ;
  logic [9:0] pageD;
  logic [8:0] offsetQ;
  logic [8:0] offsetD;
  logic mode3Q;
  logic mode3D;
  logic standbyQ;
  logic standbyD;
  logic csFall;
  logic doneRise;

  always_comb
  begin
    csPipeD = {csPipeQ[1:0], link.csN};
    donePipeD = {donePipeQ[1:0], doneQ};
    csFall = csPipeQ[2] & ~csPipeQ[1];
    doneRise = donePipeQ[1] & ~donePipeQ[2];
    frameOkD = frameOkQ;
    cmdValidD = 1'b0;
    opD = opQ;
    pageD = pageQ;
    offsetD = offsetQ;
    mode3D = mode3Q;
    if (csFall)
    begin
      frameOkD = 1'b1;
    end
    if (doneRise && frameOkQ)
    begin
      cmdValidD = 1'b1;
      opD = capQ[31:24];
      pageD = capQ[flash_link_pkg::PAGE_ADDR_MSB:
                   flash_link_pkg::PAGE_ADDR_LSB];
      offsetD = capQ[flash_link_pkg::BYTE_OFFSET_MSB:
                     flash_link_pkg::BYTE_OFFSET_LSB];
      mode3D = sckIdleQ;
    end
    standbyD = csPipeQ[1];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      // The pipe keeps following select through reset. A fall that
      // happened inside reset, except in its last two cycles, is used up there,
      // so it can never qualify the frame that it opened once reset ends.
      csPipeQ <= csPipeD;
      donePipeQ <= 3'h0;
      // frames during reset dropped
      // A frame whose select fell inside reset, except in its last two cycles, stays unqualified.
      frameOkQ <= 1'b0;
      cmdValidQ <= 1'b0;
      opQ <= 8'h0;
      pageQ <= 10'h0;
      offsetQ <= 9'h0;
      mode3Q <= 1'b1;
      standbyQ <= 1'b0;
    end
    else
    begin
      csPipeQ <= csPipeD;
      donePipeQ <= donePipeD;
      frameOkQ <= frameOkD;
      cmdValidQ <= cmdValidD;
      opQ <= opD;
      pageQ <= pageD;
      offsetQ <= offsetD;
      mode3Q <= mode3D;
      standbyQ <= standbyD;
    end
  end

  assign cmdValid = cmdValidQ;
  assign cmdOpcode = opQ;
  assign cmdPage = pageQ;
  assign cmdOffset = offsetQ;
  assign cmdMode3 = mode3Q;
  assign standby = standbyQ;

endmodule : flash_device_end

// ==== flash_link_monitor.sv ====
// Checker of timing and framing on the serial link wires.
`timescale 1ns/1ps
module flash_link_monitor (
  input wire logic clock, // System clock.
  input wire logic rst, // Host reset.
  input wire logic csN, // Select, active low.
  input wire logic sck, // Serial clock.
  input wire logic si, // Data into the device.
  input wire logic so, // Data out of the device.
  input wire logic soOeN // Output enable, active low.
);
  // ------------------------------------------------------------
  // Rise counter and properties
  // ------------------------------------------------------------
  logic sckQ;
  logic [6:0] riseQ;
  logic [6:0] riseD;
  logic edgeUp;
  assign edgeUp = sck && !sckQ && !csN;
  always_comb
  begin
    riseD = riseQ + 7'(edgeUp);
    if (csN)
      riseD = 7'h0;
  end
  always_ff @(posedge clock)
  begin
    sckQ <= sck;
    riseQ <= rst ? 7'h0 : riseD;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_so_released: assert property (soOeN)
    else $error("serial output enabled");
  chk_so_quiet: assert property (!so)
    else $error("serial output not low");
  chk_reset_idle: assert property ($fell(rst) |-> csN && sck)
    else $error("link not idle in mode 3 after reset");
  chk_mode_stable: assert property ($fell(csN) |->
    $stable(sck) ##1 $stable(sck))
    else $error("clock moved at select fall");
  chk_si_on_low: assert property (
    !csN && !$past(csN) && $changed(si) |-> !sck)
    else $error("data changed while clock high");
  chk_frame_bits: assert property ($rose(csN) |->
    riseQ inside {7'h20, 7'h28, 7'h40})
    else $error("frame length wrong");
  chk_high_half: assert property (!csN && $rose(sck) |=> sck)
    else $error("clock high phase too short");
  chk_low_half: assert property (!csN && $fell(sck) |=> !sck ##1 sck)
    else $error("clock low phase wrong");
  chk_deselect_time: assert property ($rose(csN) |->
    csN[*8] ##1 csN[*2])
    else $error("select high time too short");
  chk_reserved_zero: assert property (
    edgeUp && riseQ >= 7'h8 && riseQ <= 7'hc |-> !si)
    else $error("reserved bit not zero");
  cover property ($fell(csN) && sck);
  cover property ($fell(csN) && !sck);
  cover property ($rose(csN) && riseQ == 7'h40);
endmodule : flash_link_monitor

// ==== testbench.sv ====
// Self-checking bench joining the host end and the device end.
`timescale 1ns/1ps
module testbench;
  // ------------------------------------------------------------
  // Stimulus, expectations and checks
  // ------------------------------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic devRst = 1'b1;
  logic cmdStart = 1'b0;
  logic [7:0] op = 8'h0;
  logic [9:0] page = 10'h0;
  logic [8:0] offset = 9'h0;
  logic mode3 = 1'b1;
  logic busy, cmdDone, cmdRefused, selectReady, writeReady;
  logic cmdValid, gotMode3, standby;
  logic [7:0] gotOp;
  logic [9:0] gotPage;
  logic [8:0] gotOffset;
  logic [31:0] seed = 32'h3;
  logic [7:0] ops [12] = '{8'h0b, 8'hd2, 8'he8, 8'h03, 8'h9f, 8'h53,
    8'h81, 8'h82, 8'h83, 8'h88, 8'h50, 8'h58};
  int nMismatch = 0;
  int totalChecks = 0;
  int nValid = 0;
  int rises = 0;
  int v0 = 0;
  always #2.5 clock = ~clock;
  flash_link_if link ();
  flash_device_end i_flash_device_end (.clock(clock), .rst(devRst),
    .link(link.device), .cmdValid(cmdValid), .cmdOpcode(gotOp),
    .cmdPage(gotPage), .cmdOffset(gotOffset), .cmdMode3(gotMode3),
    .standby(standby));
  flash_host_end #(.SELECT_WAIT_CYCLES(20), .WRITE_WAIT_CYCLES(60))
    i_flash_host_end (.clock(clock), .rst(rst), .link(link.host),
    .cmdStart(cmdStart), .cmdOpcode(op), .cmdPage(page),
    .cmdOffset(offset), .cmdMode3(mode3), .busy(busy), .cmdDone(cmdDone),
    .cmdRefused(cmdRefused), .selectReady(selectReady),
    .writeReady(writeReady));
  flash_link_monitor i_flash_link_monitor (.clock(clock), .rst(rst),
    .csN(link.csN), .sck(link.sck), .si(link.si), .so(link.so),
    .soOeN(link.soOeN));
  always @(posedge clock)
    if (cmdValid === 1'b1)
      nValid++;
  always @(posedge link.sck)
    if (link.csN === 1'b0)
      rises++;

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    xorshift = y ^ (y << 5);
  endfunction : xorshift

  function automatic int bits(input logic [7:0] o);
    bits = (o == 8'h0b) ? 40 : (o == 8'hd2 || o == 8'he8) ? 64 : 32;
  endfunction : bits

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic send(input logic [7:0] o, input logic [9:0] pg,
    input logic [8:0] of, input logic m, output logic [1:0] res);
    int n;
    rises = 0;
    v0 = nValid;
    @(posedge clock);
    op <= o;
    page <= pg;
    offset <= of;
    mode3 <= m;
    cmdStart <= 1'b1;
    @(posedge clock);
    cmdStart <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end while (cmdDone !== 1'b1 && cmdRefused !== 1'b1 && n < 600);
    res = {cmdDone, cmdRefused};
    repeat (6) @(negedge clock);
  endtask : send

  task automatic expectCmd(input logic [7:0] o, input logic [9:0] pg,
    input logic [8:0] of, input logic m);
    logic [1:0] res;
    send(o, pg, of, m, res);
    check("result", res, 2'b10);
    check("valid count", nValid - v0, 1);
    check("opcode", gotOp, o);
    check("page", gotPage, pg);
    check("offset", gotOffset, of);
    check("mode", gotMode3, m);
    check("sck rises", rises, bits(o));
    check("busy after done", busy, 1'b0);
  endtask : expectCmd

  task automatic completeRun;
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : completeRun

  initial
  begin
    #100000;
    nMismatch++;
    completeRun();
  end

  initial
  begin
    logic [1:0] res;
    int n;
    repeat (4) @(negedge clock);
    check("standby in reset", standby, 1'b0);
    check("mode in reset", gotMode3, 1'b1);
    @(posedge clock);
    rst <= 1'b0;
    devRst <= 1'b0;
    repeat (2) @(negedge clock);
    check("standby", standby, 1'b1);
    // Too early: the select wait still runs.
    send(8'h0b, 10'h0, 9'h0, 1'b1, res);
    check("early", res, 2'b01);
    $display("test early select done");
    n = 0;
    while (selectReady !== 1'b1 && n < 200)
    begin
      @(negedge clock);
      n++;
    end
    check("select ready", selectReady, 1'b1);
    send(8'h82, 10'h1, 9'h1, 1'b1, res);
    check("write lock", res, 2'b01);
    check("no frame", nValid, 0);
    check("write ready early", writeReady, 1'b0);
    $display("test write lock done");
    // Reads come first, so the write wait has run out by the writes.
    foreach (ops[i])
    begin
      seed = xorshift(seed);
      expectCmd(ops[i], seed[9:0], seed[18:10], seed[19]);
    end
    expectCmd(8'he8, 10'h3ff, 9'h107, 1'b0);
    check("write ready", writeReady, 1'b1);
    $display("test opcodes done");
    fork
      send(8'hd2, 10'h155, 9'h0aa, 1'b1, res);
      begin
        repeat (20) @(negedge clock);
        check("busy in frame", busy, 1'b1);
        check("standby in frame", standby, 1'b0);
      end
      begin
        repeat (40) @(posedge clock);
        devRst <= 1'b1;
        repeat (2) @(posedge clock);
        devRst <= 1'b0;
      end
    join
    check("dropped frame", nValid - v0, 0);
    expectCmd(8'h03, 10'h2aa, 9'h155, 1'b1);
    $display("test reset mid frame done");
    completeRun();
  end
endmodule : testbench
